// ---- core/pel_defines.vh ----
/*
 Constants for the protection error latch and PWM gate block:
 APB register map, field positions, cause codes and timing counts.
 Assumes a 250 MHz pclk.
*/
`ifndef PEL_DEFINES_VH
`define PEL_DEFINES_VH

`define PEL_ADDR_CTRL 12'h000
`define PEL_ADDR_STATUS 12'h004
`define PEL_ADDR_RAW 12'h008
`define PEL_ADDR_ID 12'h00c

`define PEL_CTRL_SW_FAULT 0
`define PEL_CTRL_SW_ACK 1

`define PEL_ST_FAULT 3
`define PEL_ST_EN_LED 4
`define PEL_ST_GATE 5
`define PEL_ST_ACK 6
`define PEL_ST_SW_FAULT 7
`define PEL_ST_SW_ACK 8
`define PEL_ST_CODE_HI 2
`define PEL_ST_CODE_LO 0

`define PEL_RAW_HI 6
`define PEL_RAW_LO 0
`define PEL_RAW_REQ 7

`define PEL_N_SCALAR_PINS 14

`define PEL_CODE_NONE 3'h0
`define PEL_CODE_OV 3'h1
`define PEL_CODE_UV 3'h2
`define PEL_CODE_OC 3'h3
`define PEL_CODE_OT 3'h4
`define PEL_CODE_PWR 3'h5
`define PEL_CODE_APP 3'h6
`define PEL_CODE_MAN 3'h7

`define PEL_CLK_MHZ 250
`define PEL_SW_HOLD_MS 1000
`define PEL_SW_HOLD_CYC (`PEL_SW_HOLD_MS * 1000 * `PEL_CLK_MHZ)

`define PEL_ID_VALUE 32'h0000_5e1a

`endif

// ---- core/pel_sync.v ----
/*
 Two-flop synchroniser for a vector of asynchronous pins.
 Assumes inputs are quasi-static relative to pclk; reset value is a parameter.
*/
`timescale 1ns/10ps
`default_nettype none

module pel_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= RESET_VAL;
            sync_q <= RESET_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule // pel_sync

`default_nettype wire

// ---- core/pel_top.v ----
/*
 Protection error latch and PWM gate. Gathers active-low fault inputs,
 latches a global fault with a 3-bit cause code, gates six PWM lines and
 offers an APB port for software fault trigger and acknowledge.
 Assumes all pins except the APB port are asynchronous to pclk; the analog code output is a
 digital level word for an external DAC.
*/
`timescale 1ns/10ps
`default_nettype none
`include "pel_defines.vh"

module pel_top #(
    parameter NUM_PWM = 6,
    parameter CODE_W = 8,
    parameter [31:0] SW_HOLD_CYCLES = `PEL_SW_HOLD_CYC,
    parameter [31:0] ID_VALUE = `PEL_ID_VALUE
) (
    input wire pclk,
    input wire presetn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // PWM path, active low
    input wire [NUM_PWM-1:0] ctrl_pwm_in,
    output reg [NUM_PWM-1:0] stage_pwm_out,
    output reg pwm_buffer_gate_n,
    input wire ctrl_pwm_enable_n,
    // Fault inputs, active low
    input wire ctrl_fault_trigger_n,
    input wire ext_fault_n,
    input wire app_board_fault_n,
    input wire supply_fault_n,
    input wire overtemp_fault_n,
    input wire [2:0] phase_overcurrent_n,
    input wire stage_overcurrent_in,
    input wire undervolt_fault_n,
    input wire overvolt_fault_n,
    // Acknowledge sources, active low
    input wire ctrl_ack_n,
    input wire external_ack_input,
    // Status outputs
    output reg global_fault_n,
    output reg stage_ack_n,
    output reg stage_enable,
    output reg enable_led,
    output reg cause_led_bit2,
    output reg cause_led_bit1,
    output reg cause_led_bit0,
    output reg [CODE_W-1:0] cause_code_analog
);

    localparam N_ASYNC = NUM_PWM + `PEL_N_SCALAR_PINS;

    // Synchronised pins; resets to inactive levels
    // PWM lines too: three cycles of lag buy glitch-free gating
    wire [N_ASYNC-1:0] pins_raw;
    wire [N_ASYNC-1:0] pins_s;
    assign pins_raw = {ctrl_pwm_in, ctrl_pwm_enable_n, ctrl_fault_trigger_n, ext_fault_n,
        app_board_fault_n, supply_fault_n, overtemp_fault_n, phase_overcurrent_n,
        stage_overcurrent_in, undervolt_fault_n, overvolt_fault_n, ctrl_ack_n,
        external_ack_input};

    pel_sync #(
        .WIDTH(N_ASYNC),
        .RESET_VAL({N_ASYNC{1'b1}})
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    wire [NUM_PWM-1:0] pwm_s;
    wire en_req_n_s;
    wire ctrl_trig_n_s;
    wire ext_fault_n_s;
    wire app_n_s;
    wire pwr_n_s;
    wire ot_n_s;
    wire [2:0] phase_oc_n_s;
    wire stage_oc_n_s;
    wire uv_n_s;
    wire ov_n_s;
    wire ctrl_ack_n_s;
    wire ext_ack_n_s;
    assign {pwm_s, en_req_n_s, ctrl_trig_n_s, ext_fault_n_s, app_n_s, pwr_n_s, ot_n_s,
        phase_oc_n_s, stage_oc_n_s, uv_n_s, ov_n_s, ctrl_ack_n_s, ext_ack_n_s} = pins_s;

    // Software one-shots, one second each
    reg sw_fault_q;
    reg sw_ack_q;
    reg [31:0] sw_fault_cnt_q;
    reg [31:0] sw_ack_cnt_q;

    // APB: zero wait state, every access completes in its access cycle
    wire apb_wr;
    wire rd_setup;
    wire addr_ok;
    assign apb_wr = psel & penable & pwrite;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign addr_ok = (paddr == `PEL_ADDR_CTRL) || (paddr == `PEL_ADDR_STATUS) ||
        (paddr == `PEL_ADDR_RAW) || (paddr == `PEL_ADDR_ID);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;

    wire wr_ctrl;
    assign wr_ctrl = apb_wr && (paddr == `PEL_ADDR_CTRL);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_fault_q <= 1'b0;
            sw_fault_cnt_q <= 32'h0000_0000;
        end else if (wr_ctrl && pwdata[`PEL_CTRL_SW_FAULT]) begin
            sw_fault_q <= 1'b1;
            sw_fault_cnt_q <= SW_HOLD_CYCLES - 32'h0000_0001;
        end else if (sw_fault_q) begin
            if (sw_fault_cnt_q == 32'h0000_0000) begin
                sw_fault_q <= 1'b0;
            end else begin
                sw_fault_cnt_q <= sw_fault_cnt_q - 32'h0000_0001;
            end
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_ack_q <= 1'b0;
            sw_ack_cnt_q <= 32'h0000_0000;
        end else if (wr_ctrl && pwdata[`PEL_CTRL_SW_ACK]) begin
            sw_ack_q <= 1'b1;
            sw_ack_cnt_q <= SW_HOLD_CYCLES - 32'h0000_0001;
        end else if (sw_ack_q) begin
            if (sw_ack_cnt_q == 32'h0000_0000) begin
                sw_ack_q <= 1'b0;
            end else begin
                sw_ack_cnt_q <= sw_ack_cnt_q - 32'h0000_0001;
            end
        end
    end

    // Fault causes, active high
    wire f_man;
    wire f_app;
    wire f_pwr;
    wire f_ot;
    wire f_oc;
    wire f_uv;
    wire f_ov;
    assign f_man = ~ctrl_trig_n_s | sw_fault_q | ~ext_fault_n_s;
    assign f_app = ~app_n_s;
    assign f_pwr = ~pwr_n_s;
    assign f_ot = ~ot_n_s;
    assign f_oc = ~(&phase_oc_n_s) | ~stage_oc_n_s;
    assign f_uv = ~uv_n_s;
    assign f_ov = ~ov_n_s;

    // Highest numeric code wins among simultaneous causes
    reg [2:0] new_code;
    always @* begin
        if (f_man) begin
            new_code = `PEL_CODE_MAN;
        end else if (f_app) begin
            new_code = `PEL_CODE_APP;
        end else if (f_pwr) begin
            new_code = `PEL_CODE_PWR;
        end else if (f_ot) begin
            new_code = `PEL_CODE_OT;
        end else if (f_oc) begin
            new_code = `PEL_CODE_OC;
        end else if (f_uv) begin
            new_code = `PEL_CODE_UV;
        end else if (f_ov) begin
            new_code = `PEL_CODE_OV;
        end else begin
            new_code = `PEL_CODE_NONE;
        end
    end

    wire any_fault;
    wire ack_any;
    assign any_fault = (new_code != `PEL_CODE_NONE);
    assign ack_any = ~ctrl_ack_n_s | ~ext_ack_n_s | sw_ack_q;

    // Latch: reset enters manual fault; a live cause beats acknowledge,
    // so an ack cannot clear a fault whose cause is still present
    localparam ST_READY = 1'b0;
    localparam ST_FAULT = 1'b1;

    reg state_q;
    reg state_d;
    reg [2:0] code_q;
    reg [2:0] code_d;
    wire fault_latched;
    assign fault_latched = (state_q == ST_FAULT);

    always @* begin
        state_d = state_q;
        code_d = code_q;
        case (state_q)
            ST_READY: begin
                if (any_fault) begin
                    state_d = ST_FAULT;
                    code_d = new_code;
                end
            end
            ST_FAULT: begin
                if (any_fault) begin
                    // A lower cause never hides a higher one already shown
                    if (new_code > code_q) begin
                        code_d = new_code;
                    end
                end else if (ack_any) begin
                    state_d = ST_READY;
                    code_d = `PEL_CODE_NONE;
                end
            end
            default: begin
                state_d = ST_FAULT;
                code_d = `PEL_CODE_MAN;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_FAULT;
            code_q <= `PEL_CODE_MAN;
        end else begin
            state_q <= state_d;
            code_q <= code_d;
        end
    end

    // PWM gate: no fault, no ack in progress, request active
    wire gate_on;
    assign gate_on = ~fault_latched & ~ack_any & ~en_req_n_s;

    // One gate per line; a closed gate parks the line at its idle level
    wire [NUM_PWM-1:0] pwm_gated;
    genvar g;
    generate
        for (g = 0; g < NUM_PWM; g = g + 1) begin : g_pwm
            assign pwm_gated[g] = gate_on ? pwm_s[g] : 1'b1;
        end
    endgenerate

    // Power stage side
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_buffer_gate_n <= 1'b1;
            stage_enable <= 1'b0;
            stage_pwm_out <= {NUM_PWM{1'b1}};
            stage_ack_n <= 1'b1;
        end else begin
            pwm_buffer_gate_n <= ~gate_on;
            stage_enable <= gate_on;
            stage_pwm_out <= pwm_gated;
            stage_ack_n <= ~(ack_any & en_req_n_s);
        end
    end

    // Indicators and controller side; analog word tracks the LEDs from reset on
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_led <= 1'b0;
            global_fault_n <= 1'b0;
            cause_led_bit2 <= 1'b1;
            cause_led_bit1 <= 1'b1;
            cause_led_bit0 <= 1'b1;
            cause_code_analog <= {`PEL_CODE_MAN, {(CODE_W-3){1'b0}}};
        end else begin
            enable_led <= gate_on;
            global_fault_n <= ~fault_latched;
            cause_led_bit2 <= code_q[2];
            cause_led_bit1 <= code_q[1];
            cause_led_bit0 <= code_q[0];
            // Equal steps: code scaled into the top bits of the DAC word
            cause_code_analog <= {code_q, {(CODE_W-3){1'b0}}};
        end
    end

    // Read word captured at the end of setup, so the access cycle shows
    // a flop; it reflects state one cycle before the access
    reg [31:0] rdata_d;
    always @* begin
        rdata_d = 32'h0000_0000;
        case (paddr)
            `PEL_ADDR_CTRL: begin
                rdata_d[`PEL_CTRL_SW_FAULT] = sw_fault_q;
                rdata_d[`PEL_CTRL_SW_ACK] = sw_ack_q;
            end
            `PEL_ADDR_STATUS: begin
                rdata_d[`PEL_ST_CODE_HI:`PEL_ST_CODE_LO] = code_q;
                rdata_d[`PEL_ST_FAULT] = fault_latched;
                rdata_d[`PEL_ST_EN_LED] = enable_led;
                rdata_d[`PEL_ST_GATE] = gate_on;
                rdata_d[`PEL_ST_ACK] = ack_any;
                rdata_d[`PEL_ST_SW_FAULT] = sw_fault_q;
                rdata_d[`PEL_ST_SW_ACK] = sw_ack_q;
            end
            `PEL_ADDR_RAW: begin
                rdata_d[`PEL_RAW_HI:`PEL_RAW_LO] = {f_man, f_app, f_pwr, f_ot, f_oc, f_uv, f_ov};
                rdata_d[`PEL_RAW_REQ] = ~en_req_n_s;
            end
            `PEL_ADDR_ID: begin
                rdata_d = ID_VALUE; // Arbitrary identification value
            end
            default: begin
                rdata_d = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rdata_d;
        end else if (!psel) begin
            prdata <= 32'h0000_0000;
        end
    end

endmodule // pel_top

`default_nettype wire

// ---- verification/pel_checker.sv ----
/* Port checker for pel_top.
 Bound into pel_top; one clock pclk, async reset presetn. */
`timescale 1ns/10ps
`default_nettype none
module pel_checker #(
    parameter NUM_PWM = 6,
    parameter CODE_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [NUM_PWM-1:0] ctrl_pwm_in,
    input wire logic [NUM_PWM-1:0] stage_pwm_out,
    input wire logic pwm_buffer_gate_n,
    input wire logic ctrl_pwm_enable_n,
    input wire logic overvolt_fault_n,
    input wire logic global_fault_n,
    input wire logic stage_ack_n,
    input wire logic stage_enable,
    input wire logic enable_led,
    input wire logic cause_led_bit2,
    input wire logic cause_led_bit1,
    input wire logic cause_led_bit0,
    input wire logic [CODE_W-1:0] cause_code_analog
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire [2:0] code = {cause_led_bit2, cause_led_bit1, cause_led_bit0};
    // Five samples cover the two-flop sync plus output register
    sequence s_ov; !overvolt_fault_n [*2]; endsequence
    sequence s_on; !ctrl_pwm_enable_n [*5]; endsequence
    sequence s_off; ctrl_pwm_enable_n [*5]; endsequence
    sequence s_open; !pwm_buffer_gate_n [*5]; endsequence
    property p_shut; !global_fault_n |-> pwm_buffer_gate_n; endproperty
    a_shut: assert property (p_shut) else $error("gate open in fault");
    property p_idle; pwm_buffer_gate_n && $past(pwm_buffer_gate_n) |-> &stage_pwm_out; endproperty
    a_idle: assert property (p_idle) else $error("pulse while gated");
    property p_fwd; s_open |-> stage_pwm_out == $past(ctrl_pwm_in, 3); endproperty
    a_fwd: assert property (p_fwd) else $error("pwm not forwarded");
    property p_catch; s_ov |-> ##[0:4] (!global_fault_n && code != 3'h0); endproperty
    a_catch: assert property (p_catch) else $error("fault missed");
    property p_clr; global_fault_n |-> code == 3'h0; endproperty
    a_clr: assert property (p_clr) else $error("code without fault");
    property p_led; enable_led == stage_enable && stage_enable != pwm_buffer_gate_n; endproperty
    a_led: assert property (p_led) else $error("enable led mismatch");
    property p_off; s_off |-> pwm_buffer_gate_n && !stage_enable; endproperty
    a_off: assert property (p_off) else $error("gate open without request");
    property p_ack; s_on |-> stage_ack_n; endproperty
    a_ack: assert property (p_ack) else $error("ack passed while enabled");
    property p_dac; cause_code_analog == {code, {(CODE_W-3){1'b0}}}; endproperty
    a_dac: assert property (p_dac) else $error("analog code mismatch");
endmodule // pel_checker
`default_nettype wire

// ---- verification/pel_ctrl_model.sv ----
/* Controller-side PWM source model.
 Assumes one pclk; idle lines read as pulled up. */
`timescale 1ns/10ps
`default_nettype none
module pel_ctrl_model (
    input wire logic pclk,
    input wire logic run,
    output logic [5:0] pwm_n
);
    logic [5:0] lfsr_q = 6'h01;
    always @(posedge pclk) begin
        lfsr_q <= {lfsr_q[4:0], lfsr_q[5] ^ lfsr_q[4]};
    end
    // Absent controller must give no pulses
    assign pwm_n = run ? lfsr_q : 6'h3f;
endmodule // pel_ctrl_model
`default_nettype wire

// ---- verification/pel_top_tb.sv ----
/* Testbench for pel_top: random fault sets, acks, APB.
 Assumes pel_defines.vh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "pel_defines.vh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module pel_top_tb;
    localparam logic [2:0] CODE_OF [11] = '{3'h1, 3'h2, 3'h3, 3'h3, 3'h3, 3'h3, 3'h4,
        3'h5, 3'h6, 3'h7, 3'h7};
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, run = 0;
    logic ctrl_pwm_enable_n = 1, pready, pslverr, er;
    logic [1:0] ackv = 2'h3;
    logic [10:0] fp = 11'h7ff, f;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [5:0] ctrl_pwm_in, stage_pwm_out;
    logic pwm_buffer_gate_n, global_fault_n, stage_ack_n, stage_enable, enable_led;
    logic cause_led_bit2, cause_led_bit1, cause_led_bit0;
    logic [7:0] cause_code_analog;
    int num_errors = 0, num_checks = 0;
    wire [2:0] code = {cause_led_bit2, cause_led_bit1, cause_led_bit0};
    pel_top #(.SW_HOLD_CYCLES(20)) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .ctrl_pwm_in, .stage_pwm_out, .pwm_buffer_gate_n, .ctrl_pwm_enable_n,
        .ctrl_fault_trigger_n(fp[10]), .ext_fault_n(fp[9]), .app_board_fault_n(fp[8]),
        .supply_fault_n(fp[7]), .overtemp_fault_n(fp[6]), .phase_overcurrent_n(fp[5:3]),
        .stage_overcurrent_in(fp[2]), .undervolt_fault_n(fp[1]), .overvolt_fault_n(fp[0]),
        .ctrl_ack_n(ackv[0]), .external_ack_input(ackv[1]), .global_fault_n, .stage_ack_n,
        .stage_enable, .enable_led, .cause_led_bit2, .cause_led_bit1, .cause_led_bit0,
        .cause_code_analog
    );
    pel_ctrl_model u_ctrl (.pclk, .run, .pwm_n(ctrl_pwm_in));
    function automatic logic [2:0] exp_code(input logic [10:0] v);
        exp_code = 3'h0;
        for (int i = 0; i < 11; i++) if (!v[i] && CODE_OF[i] > exp_code) exp_code = CODE_OF[i];
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    task automatic ack(input int s);
        if (s == 2) apb(1, `PEL_ADDR_CTRL, 32'h2, rd, er);
        else begin
            ackv[s] <= 0;
            tick(6);
            ackv[s] <= 1;
        end
        tick(30);
    endtask
    task automatic results;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial forever #2 pclk = ~pclk;
    initial begin
        repeat (6000) @(posedge pclk);
        num_errors++;
        results();
    end
    initial begin
        void'($urandom(75122));
        tick(5);
        presetn <= 1;
        tick(6);
        `CHK({global_fault_n, code, cause_code_analog}, {1'b0, 3'h7, 8'he0})
        apb(0, `PEL_ADDR_STATUS, 32'h0, rd, er);
        `CHK(rd, 32'h0000_000f)
        ackv[0] <= 0;
        tick(6);
        `CHK({stage_ack_n, pwm_buffer_gate_n}, 2'b01)
        ackv[0] <= 1;
        tick(6);
        `CHK({global_fault_n, code, enable_led}, 5'h10)
        run <= 1;
        ctrl_pwm_enable_n <= 0;
        tick(8);
        `CHK({pwm_buffer_gate_n, enable_led, stage_enable}, 3'b011)
        ackv[1] <= 0;
        tick(6);
        `CHK({stage_ack_n, pwm_buffer_gate_n, global_fault_n}, 3'b111)
        ackv[1] <= 1;
        tick(6);
        `CHK({pwm_buffer_gate_n, enable_led}, 2'b01)
        ctrl_pwm_enable_n <= 1;
        for (int i = 0; i < 24; i++) begin
            f = (i < 11) ? 11'h7ff : 11'($urandom);
            f[i % 11] = 1'b0;
            fp <= f;
            tick(8);
            `CHK({code, global_fault_n, stage_pwm_out}, {exp_code(f), 7'h3f})
            `CHK(cause_code_analog, {exp_code(f), 5'h0})
            if (i == 5) begin
                ack(0);
                `CHK(code, exp_code(f))
                apb(0, `PEL_ADDR_RAW, 32'h0, rd, er);
                `CHK(rd, 32'h0000_0004)
            end
            fp <= 11'h7ff;
            tick(4);
            ack(i % 3);
            `CHK({code, enable_led}, 4'h0)
        end
        apb(1, `PEL_ADDR_CTRL, 32'h1, rd, er);
        apb(0, `PEL_ADDR_CTRL, 32'h0, rd, er);
        `CHK(rd[0], 1'b1)
        tick(25);
        apb(0, `PEL_ADDR_CTRL, 32'h0, rd, er);
        `CHK({rd[0], code}, 4'h7)
        ack(2);
        apb(0, 12'h010, 32'h0, rd, er);
        `CHK({er, rd}, 33'h100000000)
        results();
    end
endmodule // pel_top_tb
bind pel_top pel_checker #(.NUM_PWM(NUM_PWM), .CODE_W(CODE_W)) u_chk (
    .pclk, .presetn, .ctrl_pwm_in, .stage_pwm_out, .pwm_buffer_gate_n, .ctrl_pwm_enable_n,
    .overvolt_fault_n, .global_fault_n, .stage_ack_n, .stage_enable, .enable_led,
    .cause_led_bit2, .cause_led_bit1, .cause_led_bit0, .cause_code_analog
);
`default_nettype wire
